/* rtl/alr_regs.svh */
/*
  Register offsets, field positions, reset values and level constants for the
  automatic level control block.
  Assumes an 8-bit register port with a 4-bit word address and 16-bit samples.
*/
`ifndef ALR_REGS_SVH
`define ALR_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ALR_ADDR_CTRL 4'h0
`define ALR_ADDR_LIMIT 4'h1
`define ALR_ADDR_RECOV 4'h2
`define ALR_ADDR_REC_CEIL 4'h3
`define ALR_ADDR_PB_CEIL 4'h4
`define ALR_ADDR_REC_MAN 4'h5
`define ALR_ADDR_PB_MAN 4'h6
`define ALR_ADDR_GAIN 4'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define ALR_CTRL_PATH 0
`define ALR_CTRL_REC_EN 1
`define ALR_CTRL_PB_EN 2
`define ALR_CTRL_ZC_DIS 3
`define ALR_CTRL_PWR 4
`define ALR_LIM_THR 0
`define ALR_LIM_ATT 2
`define ALR_LIM_ZCTO 4
`define ALR_LIM_WAIT 6
`define ALR_REC_STEP 0
`define ALR_REC_FAST 2

// ****************************************************************
// Reset values
// ****************************************************************
`define ALR_RST_CTRL 8'h11
`define ALR_RST_LIMIT 8'h01
`define ALR_RST_RECOV 8'h00
`define ALR_RST_REC_CEIL 8'hc5
`define ALR_RST_PB_CEIL 6'h28
`define ALR_RST_MAN 8'h91

// ****************************************************************
// Gain codes and timing
// ****************************************************************
`define ALR_GAIN_MAX 8'hf1
`define ALR_GAIN_UNITY 9'h091
`define ALR_RB_TOP 8'h0e
`define ALR_RB_MUTE 8'hff
`define ALR_TO_BASE 11'h080

// ****************************************************************
// Output levels, magnitude scaled by 2^14, full scale is 2^29
// ****************************************************************
`define ALR_LVL_M2P5 40'h0017ff3fe0
`define ALR_LVL_M4P1 40'h0013f58ee0
`define ALR_LVL_M6P0 40'h001009be50
`define ALR_LVL_M8P5 40'h000c06df68
`define ALR_LVL_M12 40'h000809b570
`define ALR_LVL_FS 40'h0020000000
`define ALR_LVL_FS6 40'h003fd92760
`define ALR_LVL_FS12 40'h007f64ea40

`endif

/* rtl/alr_pkg.sv */
/*
  Types shared by the automatic level control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package alr_pkg;

  // Origin of the gain change that waits for a zero crossing.
  typedef enum logic [1:0]
  {
    ALR_PEND_NONE = 2'b00,
    ALR_PEND_LIMIT = 2'b01,
    ALR_PEND_RECOVER = 2'b10,
    ALR_PEND_MANUAL = 2'b11
  } alr_pend_type;

endpackage

/* rtl/alr_level_ctrl.sv */
/*
  Automatic level control with limiter and recovery for one mono audio path,
  plus the register port that configures it and reads the live gain back.
  Assumes one sample strobe per sample period on sys_clk, samples in 16-bit
  two's complement, and a host that keeps the control fields still while
  level control runs.
*/
`timescale 1ns/1ps
`include "alr_regs.svh"

module alr_level_ctrl
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Sample stream
  input wire logic sampleValid,
  input wire logic [15:0] sampleIn,
  output logic [15:0] sampleOut,
  output logic sampleOutValid
);

  // The level constants are scaled for 16-bit samples, so the width is fixed.
  localparam int DW = 16;
  localparam int LW = 40;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Gain within one 6 dB octave, 0.375 dB apart, scaled by 2^14.
  // An octave is taken as an exact doubling; the 0.02 dB error per octave
  // is the price of replacing a full gain table by a shift.
  localparam logic [14:0] OCT_STEP [16] = '{
    15'h4000, 15'h42d3, 15'h45c5, 15'h48d9, 15'h4c10, 15'h4f6a, 15'h52ed, 15'h5696,
    15'h5a67, 15'h5e64, 15'h628e, 15'h66e7, 15'h6b72, 15'h702f, 15'h7522, 15'h7a4d
  };

  function automatic logic [14:0] mantissa(input logic [3:0] r);
    return OCT_STEP[r];
  endfunction

  // Period in samples for a 2-bit timing field.
  function automatic logic [10:0] periodLen(input logic [1:0] sel);
    return `ALR_TO_BASE << sel;
  endfunction

  // Gain decrement that stops at mute instead of wrapping.
  function automatic logic [7:0] subSat(input logic [7:0] g, input logic [3:0] s);
    return (g > {4'h0, s}) ? g - {4'h0, s} : 8'h00;
  endfunction

  // Codes above +36 dB would wrap the readback, so they stop at the top.
  function automatic logic [7:0] capTop(input logic [7:0] g);
    return (g > `ALR_GAIN_MAX) ? `ALR_GAIN_MAX : g;
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] limit_r, limit_nxt;
  logic [7:0] recov_r, recov_nxt;
  logic [7:0] recCeil_r, recCeil_nxt;
  logic [5:0] pbCeil_r, pbCeil_nxt;
  logic [7:0] recMan_r, recMan_nxt;
  logic [7:0] pbMan_r, pbMan_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic [7:0] gain_r, gain_nxt;
  logic [7:0] gainCode;

  // Live gain in readback code: top of range is 0EH, mute is FFH.
  assign gainCode = (gain_r == 8'h00) ? `ALR_RB_MUTE :
                    `ALR_RB_TOP + (`ALR_GAIN_MAX - gain_r);

  // Writes land in the addressed register; reads answer in the next cycle
  // only, and unmapped addresses read as zero.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    limit_nxt = limit_r;
    recov_nxt = recov_r;
    recCeil_nxt = recCeil_r;
    pbCeil_nxt = pbCeil_r;
    recMan_nxt = recMan_r;
    pbMan_nxt = pbMan_r;
    rdData_nxt = 8'h00;
    if (regWr)
    begin
      unique case (regAddr)
        `ALR_ADDR_CTRL: ctrl_nxt = {3'h0, regWrData[4:0]};
        `ALR_ADDR_LIMIT: limit_nxt = regWrData;
        `ALR_ADDR_RECOV: recov_nxt = {4'h0, regWrData[3:0]};
        `ALR_ADDR_REC_CEIL: recCeil_nxt = regWrData;
        `ALR_ADDR_PB_CEIL: pbCeil_nxt = regWrData[5:0];
        `ALR_ADDR_REC_MAN: recMan_nxt = regWrData;
        `ALR_ADDR_PB_MAN: pbMan_nxt = regWrData;
        default: ;
      endcase
    end
    if (regRd)
    begin
      unique case (regAddr)
        `ALR_ADDR_CTRL: rdData_nxt = ctrl_r;
        `ALR_ADDR_LIMIT: rdData_nxt = limit_r;
        `ALR_ADDR_RECOV: rdData_nxt = recov_r;
        `ALR_ADDR_REC_CEIL: rdData_nxt = recCeil_r;
        `ALR_ADDR_PB_CEIL: rdData_nxt = {2'h0, pbCeil_r};
        `ALR_ADDR_REC_MAN: rdData_nxt = recMan_r;
        `ALR_ADDR_PB_MAN: rdData_nxt = pbMan_r;
        `ALR_ADDR_GAIN: rdData_nxt = gainCode;
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  // Register storage.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl_r <= `ALR_RST_CTRL;
      limit_r <= `ALR_RST_LIMIT;
      recov_r <= `ALR_RST_RECOV;
      recCeil_r <= `ALR_RST_REC_CEIL;
      pbCeil_r <= `ALR_RST_PB_CEIL;
      recMan_r <= `ALR_RST_MAN;
      pbMan_r <= `ALR_RST_MAN;
      rdData_r <= 8'h00;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      limit_r <= limit_nxt;
      recov_r <= recov_nxt;
      recCeil_r <= recCeil_nxt;
      pbCeil_r <= pbCeil_nxt;
      recMan_r <= recMan_nxt;
      pbMan_r <= pbMan_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  logic pathRec, alcOn, zcDis, power;
  logic [1:0] thrSel, attSel, zcSel, waitSel, stepSel, fastSel;
  logic [7:0] ceiling, manualGain, pbCeilGain;
  logic [10:0] zcLen, waitLen;

  assign pathRec = ctrl_r[`ALR_CTRL_PATH];
  assign alcOn = pathRec ? ctrl_r[`ALR_CTRL_REC_EN] : ctrl_r[`ALR_CTRL_PB_EN];
  assign zcDis = ctrl_r[`ALR_CTRL_ZC_DIS];
  assign power = ctrl_r[`ALR_CTRL_PWR];
  assign thrSel = limit_r[`ALR_LIM_THR +: 2];
  assign attSel = limit_r[`ALR_LIM_ATT +: 2];
  assign zcSel = limit_r[`ALR_LIM_ZCTO +: 2];
  assign waitSel = limit_r[`ALR_LIM_WAIT +: 2];
  assign stepSel = recov_r[`ALR_REC_STEP +: 2];
  assign fastSel = recov_r[`ALR_REC_FAST +: 2];
  assign zcLen = periodLen(zcSel);
  assign waitLen = periodLen(waitSel);

  // Playback ceiling code c sits at gain code 4c+1 (1.5 dB is four steps).
  assign pbCeilGain = {pbCeil_r, 2'b01};
  // Ceiling or manual codes above +36 dB on either path are held at the top.
  assign ceiling = capTop(pathRec ? recCeil_r : pbCeilGain);
  assign manualGain = capTop(pathRec ? recMan_r : pbMan_r);

  // ****************************************************************
  // Gain stage and level detection
  // ****************************************************************
  logic sign, over, resetBand, zeroCross;
  logic [DW-1:0] mag, outSample;
  logic signed [8:0] dGain;
  logic signed [4:0] octave;
  logic [DW+14:0] prod;
  logic [LW-1:0] level, thrLvl, rstLvl;
  logic [1:0] tier;
  logic [3:0] limSteps;

  assign sign = sampleIn[DW-1];
  assign mag = sign ? DW'(~sampleIn + 16'h0001) : sampleIn;
  assign dGain = $signed({1'b0, gain_r}) - $signed(`ALR_GAIN_UNITY);
  assign octave = dGain[8:4];
  assign prod = mag * mantissa(dGain[3:0]);

  // Output magnitude before saturation, kept wide so that levels above
  // full scale can still be told apart for the attenuation tiers.
  always_comb
  begin
    if (gain_r == 8'h00)
      level = '0;
    else if (!octave[4])
      level = LW'(prod) << octave[2:0];
    else
      level = LW'(prod) >> (5'(-octave));
  end

  // Saturating output sample.
  assign outSample = (level >= `ALR_LVL_FS) ? (sign ? 16'h8000 : 16'h7fff) :
                     sign ? (~{1'b0, level[28:14]} + 16'h0001) : {1'b0, level[28:14]};

  // Detection threshold and lower edge of the wait-reset band.
  always_comb
  begin
    unique case (thrSel)
      2'b00: {thrLvl, rstLvl} = {`ALR_LVL_M2P5, `ALR_LVL_M4P1};
      2'b01: {thrLvl, rstLvl} = {`ALR_LVL_M4P1, `ALR_LVL_M6P0};
      2'b10: {thrLvl, rstLvl} = {`ALR_LVL_M6P0, `ALR_LVL_M8P5};
      2'b11: {thrLvl, rstLvl} = {`ALR_LVL_M8P5, `ALR_LVL_M12};
    endcase
  end

  assign over = level >= thrLvl;
  assign resetBand = !over && (level >= rstLvl);
  assign tier = (level >= `ALR_LVL_FS12) ? 2'd3 :
                (level >= `ALR_LVL_FS6) ? 2'd2 :
                (level >= `ALR_LVL_FS) ? 2'd1 : 2'd0;

  // Attenuation count per step code and tier.
  always_comb
  begin
    unique case (attSel)
      2'b00: limSteps = 4'd1;
      2'b01: limSteps = 4'd2;
      2'b10: limSteps = (tier == 2'd3) ? 4'd8 : (tier == 2'd0) ? 4'd2 : 4'd4;
      2'b11: limSteps = 4'(4'd1 << tier);
    endcase
  end

  // ****************************************************************
  // Limiter and recovery sequencer
  // ****************************************************************
  alr_pkg::alr_pend_type pend_r, pend_nxt;
  logic [7:0] target_r, target_nxt;
  logic [10:0] zcCnt_r, zcCnt_nxt, waitCnt_r, waitCnt_nxt, waitEnd;
  logic fast_r, fast_nxt, prevSign_r, prevSign_nxt, outValid_r, outValid_nxt;
  logic [15:0] out_r, out_nxt;
  logic [8:0] upSum;

  // A sign change or an exact zero counts as a crossing.
  assign zeroCross = (sign != prevSign_r) || (sampleIn == 16'h0000);
  // Fast recovery divides the wait; code 11 is not allowed and acts as 16x.
  assign waitEnd = fast_r ? (waitLen >> ((fastSel == 2'b00) ? 2 :
                   (fastSel == 2'b01) ? 3 : 4)) : waitLen;

  // One decision per sample strobe; nothing moves while the filter block
  // is powered down, so the gain is kept for the next power-up.
  always_comb
  begin
    gain_nxt = gain_r;
    pend_nxt = pend_r;
    target_nxt = target_r;
    zcCnt_nxt = zcCnt_r;
    waitCnt_nxt = waitCnt_r;
    fast_nxt = fast_r;
    prevSign_nxt = prevSign_r;
    out_nxt = out_r;
    outValid_nxt = 1'b0;
    upSum = 9'h000;
    if (sampleValid && power)
    begin
      out_nxt = outSample;
      outValid_nxt = 1'b1;
      prevSign_nxt = sign;
      // A waiting change lands at a crossing or when the timeout runs out.
      if (pend_r != alr_pkg::ALR_PEND_NONE)
      begin
        if (zeroCross || (zcCnt_r >= zcLen - 11'h001))
        begin
          gain_nxt = target_r;
          pend_nxt = alr_pkg::ALR_PEND_NONE;
          zcCnt_nxt = 11'h000;
        end
        else
          zcCnt_nxt = zcCnt_r + 11'h001;
      end
      if (!alcOn)
      begin
        // Manual gain; rewriting the same value keeps the timeout running.
        fast_nxt = 1'b0;
        waitCnt_nxt = 11'h000;
        if (manualGain != ((pend_nxt != alr_pkg::ALR_PEND_NONE) ? target_r : gain_nxt))
        begin
          target_nxt = manualGain;
          pend_nxt = alr_pkg::ALR_PEND_MANUAL;
          zcCnt_nxt = 11'h000;
        end
      end
      else if (over)
      begin
        waitCnt_nxt = 11'h000;
        if (tier != 2'd0)
          fast_nxt = 1'b1;
        if (zcDis)
        begin
          gain_nxt = subSat(gain_nxt, 4'd1);
          pend_nxt = alr_pkg::ALR_PEND_NONE;
          zcCnt_nxt = 11'h000;
        end
        else
        begin
          // Each new hit deepens a limiter change that is still waiting.
          target_nxt = subSat((pend_nxt == alr_pkg::ALR_PEND_LIMIT) ? target_r :
                              gain_nxt, limSteps);
          if (pend_nxt != alr_pkg::ALR_PEND_LIMIT)
            zcCnt_nxt = 11'h000;
          pend_nxt = alr_pkg::ALR_PEND_LIMIT;
        end
      end
      else if (resetBand)
        waitCnt_nxt = 11'h000;
      else if (waitCnt_r >= waitEnd - 11'h001)
      begin
        // Quiet for a whole wait period: one recovery step, then wait again.
        waitCnt_nxt = 11'h000;
        if (gain_nxt >= ceiling)
          fast_nxt = 1'b0;
        else if (pend_nxt == alr_pkg::ALR_PEND_NONE)
        begin
          upSum = {1'b0, gain_nxt} + {7'h00, stepSel} + 9'h001;
          target_nxt = (upSum > {1'b0, ceiling}) ? ceiling : upSum[7:0];
          pend_nxt = alr_pkg::ALR_PEND_RECOVER;
          zcCnt_nxt = 11'h000;
        end
      end
      else
        waitCnt_nxt = waitCnt_r + 11'h001;
    end
  end

  // Sequencer state and the output sample.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      gain_r <= `ALR_RST_MAN;
      pend_r <= alr_pkg::ALR_PEND_NONE;
      target_r <= `ALR_RST_MAN;
      zcCnt_r <= 11'h000;
      waitCnt_r <= 11'h000;
      fast_r <= 1'b0;
      prevSign_r <= 1'b0;
      out_r <= 16'h0000;
      outValid_r <= 1'b0;
    end
    else
    begin
      gain_r <= gain_nxt;
      pend_r <= pend_nxt;
      target_r <= target_nxt;
      zcCnt_r <= zcCnt_nxt;
      waitCnt_r <= waitCnt_nxt;
      fast_r <= fast_nxt;
      prevSign_r <= prevSign_nxt;
      out_r <= out_nxt;
      outValid_r <= outValid_nxt;
    end
  end

  assign sampleOut = out_r;
  assign sampleOutValid = outValid_r;

endmodule

/* sim/alr_sample_src.sv */
/*
  Sample source standing in for the converter data path ahead of the block.
  Assumes the block answers each accepted sample one cycle later.
*/
`timescale 1ns/1ps

module alr_sample_src
(
  // Clock
  input wire logic sys_clk,
  // Samples toward the block
  output logic sampleValid,
  output logic [15:0] sampleIn,
  // Samples back from the block
  input wire logic [15:0] sampleOut,
  input wire logic sampleOutValid
);
  // Idle cycles before each sample are this plus one; raise it to act as a slow source.
  int gap = 0;

  // ****************************************
  // Stream driver
  // ****************************************
  // Quiet stream until the first call.
  initial
  begin
    sampleValid = 1'b0;
    sampleIn = 16'h0000;
  end

  // Outside the strobe the data line shows the inverse of the last sample,
  // so a block that looks at it late sees wrong data, not a lucky copy.
  task automatic send(input logic [15:0] v, output logic [15:0] got, output logic ok);
    repeat (gap + 1) @(posedge sys_clk);
    sampleValid <= 1'b1;
    sampleIn <= v;
    @(posedge sys_clk);
    sampleValid <= 1'b0;
    sampleIn <= ~v;
    #1;
    ok = sampleOutValid;
    got = sampleOut;
  endtask
endmodule

/* sim/alr_level_ctrl_asserts.sv */
/*
  Port checker for the level control block, bound in at the foot.
  Assumes the register map of alr_regs.svh.
*/
`timescale 1ns/1ps
`include "alr_regs.svh"

module alr_level_ctrl_asserts
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // Sample stream
  input wire logic sampleValid,
  input wire logic [15:0] sampleIn,
  input wire logic [15:0] sampleOut,
  input wire logic sampleOutValid
);
  logic power_r;
  logic power_nxt;

  // ****************************************
  // Power shadow
  // ****************************************
  // The block's own power bit is hidden, so it is rebuilt from the writes.
  always_comb
  begin
    power_nxt = (regWr && regAddr == `ALR_ADDR_CTRL) ? regWrData[`ALR_CTRL_PWR] : power_r;
  end
  always_ff @(posedge sys_clk)
  begin
    power_r <= srst ? 1'b1 : power_nxt;
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // Stream answers come one cycle after a taken sample, and only then.
  a_out_pulse: assert property (sampleValid |=> sampleOutValid == $past(power_r))
    else $error("output pulse does not follow an accepted sample");
  a_no_stray_pulse: assert property (!$past(sampleValid) |-> !sampleOutValid)
    else $error("output pulse without a sample");
  a_out_holds: assert property (!sampleOutValid |-> $stable(sampleOut))
    else $error("output sample changed between pulses");
  a_zero_in_out: assert property (sampleValid && power_r && sampleIn == 16'h0000
    |=> sampleOut == 16'h0000)
    else $error("zero sample did not give zero output");
  a_sign_kept: assert property (sampleValid && power_r && sampleIn[15]
    |=> sampleOut[15] || sampleOut == 16'h0000)
    else $error("negative sample changed sign");
  // Read data stand for one cycle after the strobe and read zero otherwise.
  a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside the answer cycle");
  a_rd_unmapped: assert property (regRd && regAddr[3] |=> regRdData == 8'h00)
    else $error("unmapped address read nonzero");
  a_gain_range: assert property (regRd && regAddr == `ALR_ADDR_GAIN
    |=> regRdData >= `ALR_RB_TOP)
    else $error("gain readback above the top code");
endmodule

bind alr_level_ctrl alr_level_ctrl_asserts chk (.sys_clk(sys_clk), .srst(srst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .sampleValid(sampleValid), .sampleIn(sampleIn),
  .sampleOut(sampleOut), .sampleOutValid(sampleOutValid));

/* sim/tb.sv */
/*
  Self-checking bench for the level control block.
  Assumes the sample source model and the bound port checker.
*/
`timescale 1ns/1ps
`include "alr_regs.svh"

module tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic sampleValid;
  logic [15:0] sampleIn;
  logic [15:0] sampleOut;
  logic sampleOutValid;
  logic [15:0] lastOut;
  logic lastOk;
  int errors = 0;
  int comparisons = 0;

  // A 50 ns period.
  always #25 sys_clk = ~sys_clk;

  alr_level_ctrl dut (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .sampleValid(sampleValid), .sampleIn(sampleIn), .sampleOut(sampleOut),
    .sampleOutValid(sampleOutValid));
  alr_sample_src src (.sys_clk(sys_clk), .sampleValid(sampleValid),
    .sampleIn(sampleIn), .sampleOut(sampleOut), .sampleOutValid(sampleOutValid));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    check({8'h00, regRdData}, {8'h00, exp});
  endtask

  task automatic ctrl(input logic [7:0] d);
    wr(`ALR_ADDR_CTRL, d);
  endtask

  task automatic gain(input logic [7:0] exp);
    rd(`ALR_ADDR_GAIN, exp);
  endtask

  task automatic run(input logic [15:0] v, input int n);
    repeat (n) src.send(v, lastOut, lastOk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    logic [7:0] dflt [9];
    dflt = '{8'h11, 8'h01, 8'h00, 8'hc5, 8'h28, 8'h91, 8'h91, 8'h6e, 8'h00};
    for (int i = 0; i < 9; i++) rd(4'(i), dflt[i]);
    wr(`ALR_ADDR_GAIN, 8'h00);
    wr(4'hc, 8'h5a);
    rd(4'hc, 8'h00);
    gain(8'h6e);
    $display("reset values done");
  endtask

  task automatic test_limit_now();
    wr(`ALR_ADDR_LIMIT, 8'h05);
    ctrl(8'h1d);
    run(16'h7530, 2);
    gain(8'h6e);
    ctrl(8'h1b);
    run(16'h7530, 1);
    check(lastOut, 16'h7530);
    gain(8'h6f);
    run(16'h7530, 2);
    gain(8'h71);
    $display("immediate limiter done");
  endtask

  task automatic test_manual();
    ctrl(8'h11);
    wr(`ALR_ADDR_REC_MAN, 8'ha1);
    run(16'h03e8, 1);
    gain(8'h71);
    run(16'h0000, 1);
    gain(8'h5e);
    run(16'h03e8, 1);
    check(lastOut, 16'h07d0);
    // A manual change is decided on one sample and lands at a later crossing.
    ctrl(8'h10);
    run(16'h0000, 2);
    gain(8'h6e);
    ctrl(8'h01);
    run(16'h03e8, 1);
    check({15'h0000, lastOk}, 16'h0000);
    ctrl(8'h11);
    run(16'h0000, 2);
    gain(8'h5e);
    run(16'hfc18, 1);
    check(lastOut, 16'hf830);
    $display("manual gain done");
  endtask

  // Each code is hit at full scale; codes 10 and 11 take 4 and 2 steps in that tier.
  task automatic test_tiers();
    logic [7:0] rb [4];
    rb = '{8'h5f, 8'h60, 8'h62, 8'h60};
    for (int c = 0; c < 4; c++)
    begin
      ctrl(8'h11);
      wr(`ALR_ADDR_LIMIT, {4'h0, 2'(c), 2'b01});
      run(16'h0000, 2);
      ctrl(8'h13);
      run(16'h4e20, 1);
      check(lastOut, 16'h7fff);
      gain(8'h5e);
      run(16'h0000, 1);
      gain(rb[c]);
    end
    $display("attenuation tiers done");
  endtask

  task automatic test_timeout();
    ctrl(8'h11);
    wr(`ALR_ADDR_LIMIT, 8'hd1);
    run(16'h0000, 2);
    ctrl(8'h13);
    src.gap = 2;
    run(16'h2ee0, 1);
    // The change waits 256 sample periods with no crossing, not one fewer.
    run(16'h0064, 255);
    gain(8'h5e);
    run(16'h0064, 1);
    gain(8'h5f);
    src.gap = 0;
    $display("zero cross timeout done");
  endtask

  task automatic test_recover();
    ctrl(8'h11);
    wr(`ALR_ADDR_LIMIT, 8'h01);
    wr(`ALR_ADDR_RECOV, 8'h01);
    wr(`ALR_ADDR_REC_CEIL, 8'ha2);
    run(16'h0000, 2);
    ctrl(8'h13);
    run(16'h2ee0, 1);
    run(16'h0000, 100);
    gain(8'h5f);
    run(16'h251c, 1);
    run(16'h0000, 100);
    gain(8'h5f);
    run(16'h0000, 60);
    gain(8'h5d);
    run(16'h0000, 300);
    gain(8'h5d);
    run(16'h4e20, 1);
    run(16'h0000, 1);
    gain(8'h5e);
    run(16'h0000, 45);
    gain(8'h5d);
    $display("recovery done");
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The scenarios need a few thousand cycles; this limit leaves ample room.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end

  // Main sequence after a two cycle reset.
  initial
  begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    test_reset();
    test_limit_now();
    test_manual();
    test_tiers();
    test_timeout();
    test_recover();
    end_of_test();
  end
endmodule
